// *** bcdadj_consts.svh ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the decimal-adjust datapath
// Assumes: included by bare name
// Notes:   definitions only
//////////////////////////////////////////////////////////////////////////////
`ifndef BCDADJ_CONSTS_SVH
`define BCDADJ_CONSTS_SVH

`define BCDADJ_DIGIT_MAX   4'h9   // largest legal bcd digit
`define BCDADJ_DIGIT_FIX   4'h6   // correction added to a bad digit
`define BCDADJ_W_RST       8'h00  // reset value of the result byte
`define BCDADJ_DONE_RST    1'b0   // reset value of the done pulse
`define BCDADJ_PHASES      3      // edges from issue to write phase

`endif

// *** bcdadj_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: types and arithmetic for the decimal-adjust datapath
// Assumes: bcdadj_consts.svh available
// Notes:   the correction function is shared by logic and assertions
//////////////////////////////////////////////////////////////////////////////
`include "bcdadj_consts.svh"

package bcdadj_pkg;

  // status flags carried with the working register
  typedef struct packed {
    logic negative;
    logic overflow;
    logic zero;
    logic half_byte_overflow_bit;
    logic byte_overflow_bit;
  } bcdadj_flags_t;

  // one adjusted result
  typedef struct packed {
    logic [7:0] value;
    logic       carry;
  } bcdadj_res_t;

  // instruction phases after decode
  typedef enum logic [1:0] {
    BCDADJ_IDLE,
    BCDADJ_READ,
    BCDADJ_PROC,
    BCDADJ_WRITE
  } bcdadj_state_t;

  // low nibble then high nibble; low carry ripples into the high digit
  function automatic bcdadj_res_t bcdadj_fix(
    input logic [7:0] w,
    input logic       c,
    input logic       hc
  );
    logic [8:0]  sum_lo;
    logic [8:0]  sum_hi;
    bcdadj_res_t r;
    sum_lo = {1'b0, w};
    if ((w[3:0] > `BCDADJ_DIGIT_MAX) || hc)
    begin
      sum_lo = sum_lo + {5'h00, `BCDADJ_DIGIT_FIX};
    end
    sum_hi = sum_lo;
    if ((sum_lo[7:4] > `BCDADJ_DIGIT_MAX) || c || sum_lo[8])
    begin
      sum_hi = sum_lo + {1'b0, `BCDADJ_DIGIT_FIX, 4'h0};
    end
    r.value = sum_hi[7:0];
    r.carry = c | sum_hi[8] | (sum_hi != sum_lo);
    return r;
  endfunction

endpackage

// *** bcdadj_core.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: decimal adjust of the working register after a packed bcd add
// Assumes: issue, w_in and flags_in come from core logic on ref_clk
// Notes:   four-phase instruction; only the byte carry flag is altered
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

`include "bcdadj_consts.svh"

module bcdadj_core
  import bcdadj_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic          issue,
  input  wire logic [7:0]    w_in,
  input  wire bcdadj_flags_t flags_in,
  output logic [7:0]         w_out,
  output bcdadj_flags_t      flags_out,
  output logic               done,
  output logic               busy
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer and datapath state
  bcdadj_state_t state_reg;
  bcdadj_state_t state_next;
  logic [7:0]    op_reg;
  logic [7:0]    op_next;
  bcdadj_flags_t fl_reg;
  bcdadj_flags_t fl_next;
  bcdadj_res_t   res_reg;
  bcdadj_res_t   res_next;
  logic [7:0]    w_out_reg;
  logic [7:0]    w_out_next;
  bcdadj_flags_t flo_reg;
  bcdadj_flags_t flo_next;
  logic          done_reg;
  logic          done_next;
  logic          busy_reg;
  logic          busy_next;

  // issue is ignored while an adjust is in flight
  always_comb
  begin
    state_next = state_reg;
    op_next    = op_reg;
    fl_next    = fl_reg;
    res_next   = res_reg;
    w_out_next = w_out_reg;
    flo_next   = flo_reg;
    done_next  = 1'b0;
    busy_next  = busy_reg;
    case (state_reg)
      BCDADJ_IDLE:
      begin
        if (issue)
        begin
          state_next = BCDADJ_READ;
          busy_next  = 1'b1;
        end
      end
      BCDADJ_READ:
      begin
        op_next    = w_in;
        fl_next    = flags_in;
        state_next = BCDADJ_PROC;
      end
      BCDADJ_PROC:
      begin
        res_next   = bcdadj_fix(op_reg, fl_reg.byte_overflow_bit,
                                fl_reg.half_byte_overflow_bit);
        state_next = BCDADJ_WRITE;
      end
      BCDADJ_WRITE:
      begin
        w_out_next = res_reg.value;
        flo_next   = fl_reg;
        flo_next.byte_overflow_bit = res_reg.carry;
        done_next  = 1'b1;
        busy_next  = 1'b0;
        state_next = BCDADJ_IDLE;
      end
      default:
      begin
        state_next = BCDADJ_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  // registers only; the flags output idles at zero until first write
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= BCDADJ_IDLE;
      op_reg    <= `BCDADJ_W_RST;
      fl_reg    <= '0;
      res_reg   <= '0;
      w_out_reg <= `BCDADJ_W_RST;
      flo_reg   <= '0;
      done_reg  <= `BCDADJ_DONE_RST;
      busy_reg  <= 1'b0;
    end
    else if (!rst_sync_reg)
    begin
      state_reg <= BCDADJ_IDLE;
      done_reg  <= `BCDADJ_DONE_RST;
      busy_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg    <= op_next;
      fl_reg    <= fl_next;
      res_reg   <= res_next;
      w_out_reg <= w_out_next;
      flo_reg   <= flo_next;
      done_reg  <= done_next;
      busy_reg  <= busy_next;
    end
  end

  assign w_out     = w_out_reg;
  assign flags_out = flo_reg;
  assign done      = done_reg;
  assign busy      = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_start;
    (state_reg == BCDADJ_IDLE) && issue;
  endsequence

  sequence s_capture;
    s_start ##1 1'b1;
  endsequence

  a_write_timing: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    s_start |-> ##1 !done_reg [*3] ##1 done_reg)
    else $error("adjust result not written four edges after issue");

  a_writeback_value: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    s_capture |-> ##3 (w_out_reg ==
      bcdadj_fix($past(w_in, 3), $past(flags_in.byte_overflow_bit, 3),
        $past(flags_in.half_byte_overflow_bit, 3)).value))
    else $error("written byte differs from adjusted operand");

  a_low_digit_fix: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    done_reg |-> (w_out_reg[3:0] ==
      (((op_reg[3:0] > `BCDADJ_DIGIT_MAX) || fl_reg.half_byte_overflow_bit)
        ? op_reg[3:0] + `BCDADJ_DIGIT_FIX : op_reg[3:0])))
    else $error("low digit correction wrong");

  a_high_digit_fix: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    (done_reg && (op_reg[7:4] > `BCDADJ_DIGIT_MAX) && (op_reg[3:0] < 4'ha)
      && !fl_reg.half_byte_overflow_bit)
    |-> (w_out_reg[7:4] == op_reg[7:4] + `BCDADJ_DIGIT_FIX))
    else $error("high digit above nine not corrected");

  a_carry_set: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    (done_reg && ((op_reg[7:4] > `BCDADJ_DIGIT_MAX)
      || fl_reg.byte_overflow_bit)) |-> flo_reg.byte_overflow_bit)
    else $error("byte carry not set after high correction");

  a_flags_kept: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    s_capture |-> ##3 (flo_reg.half_byte_overflow_bit ==
      $past(flags_in.half_byte_overflow_bit, 3)) &&
      (flo_reg.zero == $past(flags_in.zero, 3)) &&
      (flo_reg.negative == $past(flags_in.negative, 3)) &&
      (flo_reg.overflow == $past(flags_in.overflow, 3)))
    else $error("flag other than byte carry changed");

  a_outputs_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_reg)
    (!done_reg && busy_reg) |-> $stable(w_out_reg) && $stable(flo_reg))
    else $error("outputs moved outside the write phase");

endmodule // bcdadj_core

// *** tb_bcd_decimal_adjust.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for the decimal-adjust datapath
// Assumes: 25 MHz ref_clk, done three edges after issue is taken
// Notes:   table rows first, then refusal and mid-run reset by hand
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module tb_bcd_decimal_adjust
  import bcdadj_pkg::*;
;
  logic          ref_clk      = 1'b0;
  logic          resetn       = 1'b0;
  logic          issue        = 1'b0;
  logic [7:0]    w_in         = 8'h00;
  bcdadj_flags_t flags_in     = '0;
  logic [7:0]    w_out;
  bcdadj_flags_t flags_out;
  logic          done;
  logic          busy;
  int            bad_count    = 0;
  int            total_checks = 0;
  int            cycles       = 0;
  int            n;
  // rows: w, {byte carry, half carry}, expected w, expected byte carry
  logic [18:0]   rows [10] = '{
    {8'ha5, 2'h0, 8'h05, 1'h1}, {8'hce, 2'h0, 8'h34, 1'h1},
    {8'h12, 2'h0, 8'h12, 1'h0}, {8'h19, 2'h1, 8'h1f, 1'h0},
    {8'h1a, 2'h0, 8'h20, 1'h0}, {8'h23, 2'h2, 8'h83, 1'h1},
    {8'h99, 2'h0, 8'h99, 1'h0}, {8'h9a, 2'h0, 8'h00, 1'h1},
    {8'hff, 2'h1, 8'h65, 1'h1}, {8'h00, 2'h3, 8'h66, 1'h1}};

  bcdadj_core u_dut (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .issue     (issue),
    .w_in      (w_in),
    .flags_in  (flags_in),
    .w_out     (w_out),
    .flags_out (flags_out),
    .done      (done),
    .busy      (busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // free-running clock, 40 ns period
  always #20 ref_clk = ~ref_clk;

  // cycle ceiling so a lost done cannot hang the run
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // compare and count
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one adjust; operand goes in the cycle after issue is taken
  task automatic run(input logic [7:0] w, input logic [1:0] cd,
                     input logic [2:0] nvz, input logic [7:0] ew,
                     input logic ec);
    @(posedge ref_clk);
    issue <= 1'b1;
    @(posedge ref_clk);
    issue    <= 1'b0;
    w_in     <= w;
    flags_in <= {nvz, cd[0], cd[1]};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n == 1)
        chk("busy", {7'h0, busy}, 8'h01);
    end
    while ((done !== 1'b1) && (n < 8));
    chk("latency", n[7:0], 8'h03);
    chk("w_out", w_out, ew);
    chk("flags", {3'h0, flags_out}, {3'h0, nvz, cd[0], ec});
  endtask

  // single place where the run ends
  task automatic give_verdict();
    if ((bad_count == 0) && (total_checks > 0))
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk("rst_w", w_out, 8'h00);
    chk("rst_flags", {3'h0, flags_out}, 8'h00);
    chk("rst_done", {6'h0, done, busy}, 8'h00);
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++)
      run(rows[i][18:11], rows[i][10:9], i[2:0], rows[i][8:1], rows[i][0]);
    // a second issue while busy must be ignored, not queued
    @(posedge ref_clk);
    issue <= 1'b1;
    @(posedge ref_clk);
    issue <= 1'b0;
    w_in  <= 8'h0a;
    flags_in <= '0;
    @(posedge ref_clk);
    issue <= 1'b1;
    @(posedge ref_clk);
    issue <= 1'b0;
    repeat (1) @(posedge ref_clk);
    #1;
    chk("done", {7'h0, done}, 8'h01);
    chk("w_out", w_out, 8'h10);
    n = 0;
    repeat (6)
    begin
      @(posedge ref_clk);
      #1;
      n += done;
    end
    chk("extra_done", n[7:0], 8'h00);
    // reset in mid-operation clears outputs at once
    @(posedge ref_clk);
    issue <= 1'b1;
    @(posedge ref_clk);
    issue <= 1'b0;
    w_in  <= 8'hff;
    @(posedge ref_clk);
    resetn <= 1'b0;
    #1;
    chk("mid_rst", {6'h0, done, busy}, 8'h00);
    chk("mid_rst_w", w_out, 8'h00);
    @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    run(8'hce, 2'h0, 3'h5, 8'h34, 1'h1);
    give_verdict();
  end
endmodule // tb_bcd_decimal_adjust
